// [logic/vc3_path_overhead_monitor.sv]
// Function
// - hold-off on: ignore adjustments within 3 frames
// - hold-off off: accept every pointer adjustment
// - single-bit mode uses only G1 bit 5
// - enhanced mode uses G1 bits 5,6,7
// - per-bit mode adds G1 lower nibble value
// - per-frame mode adds one per nonzero nibble
// - parity per-bit mode adds errored bit count
// - parity per-frame mode adds one at most
// - async payload flag while label equals FC
// - async flag meaningful only for DS3 payload
// - differing trace message bumps instability counter
// - counter reaching 8 declares trace unstable
// - 3 or 5 same messages clear counter
// - summary byte layout, read-only, resets zero
// - one register page per channel 2..4
// - enhanced patterns 010,101,110 for threshold frames
// - single-bit bit 5 set for threshold frames
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module vc3_path_overhead_monitor
  import vc3_poh_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // axi4-lite write
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // received path overhead, one per channel
  input  wire frame_type   frame_i [NUM_CH],
  // results
  output logic [NUM_CH-1:0] ptr_accept_o,
  output logic              irq_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // word index to channel page and register
  function automatic decode_type decode(input logic [31:0] a);
    decode_type r;
    r.idx = a[9:2];
    r.ch  = 2'(a[13:10] - PAGE_FIRST);
    r.hit = (a[31:14] == '0) && (a[1:0] == 2'h0) &&
            (a[13:10] >= PAGE_FIRST) && (a[13:10] <= PAGE_LAST);
    return r;
  endfunction

  // number of set bits in a byte
  function automatic logic [3:0] popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [3:0]  cfg_q       [NUM_CH];
  logic [4:0]  thr_q       [NUM_CH];
  logic [3:0]  mask_q      [NUM_CH];
  logic [3:0]  irq_q       [NUM_CH];
  logic [3:0]  irq_d       [NUM_CH];
  logic [3:0]  ev          [NUM_CH];
  logic [31:0] rei_cnt_q   [NUM_CH];
  logic [31:0] b3_cnt_q    [NUM_CH];
  logic [1:0]  gap_q       [NUM_CH];
  logic [1:0]  gap_d       [NUM_CH];
  logic        accept_d    [NUM_CH];
  logic        ignore_d    [NUM_CH];
  logic        rdi_q       [NUM_CH];
  logic        rdi_d       [NUM_CH];
  logic [3:0]  rdi_run_q   [NUM_CH];
  logic [3:0]  rdi_run_d   [NUM_CH];
  logic [3:0]  trace_cnt_q [NUM_CH];
  logic [3:0]  trace_cnt_d [NUM_CH];
  logic [2:0]  trace_run_q [NUM_CH];
  logic [2:0]  trace_run_d [NUM_CH];
  logic        trace_unst_q[NUM_CH];
  logic        async_q     [NUM_CH];
  logic [7:0]  summary_q   [NUM_CH];
  logic        aw_take;
  logic        ar_take;
  decode_type  wdec;
  decode_type  rdec;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  // ****************************************************************
  // per-channel frame processing, next values
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      // pointer hold-off: gap counts frames since last accepted move
      ignore_d[c] = frame_i[c].ptr_adj && cfg_q[c][CFG_HOLDOFF] &&
                    (gap_q[c] < HOLDOFF_FRAMES);
      accept_d[c] = frame_i[c].ptr_adj && !ignore_d[c];
      gap_d[c]    = gap_q[c];
      if (accept_d[c]) begin
        gap_d[c] = 2'h0;
      end else if (frame_i[c].valid && gap_q[c] != HOLDOFF_FRAMES) begin
        gap_d[c] = gap_q[c] + 2'h1;
      end
      // remote defect: run of frames disagreeing with current state
      rdi_d[c]     = rdi_q[c];
      rdi_run_d[c] = rdi_run_q[c];
      if (frame_i[c].valid) begin
        if (rdi_match(frame_i[c].g1, cfg_q[c][CFG_RDI_TYPE]) ==
            rdi_q[c]) begin
          rdi_run_d[c] = 4'h0;
        end else if (rdi_run_q[c] + 4'h1 >= thr_q[c][3:0]) begin
          rdi_d[c]     = !rdi_q[c];
          rdi_run_d[c] = 4'h0;
        end else begin
          rdi_run_d[c] = rdi_run_q[c] + 4'h1;
        end
      end
      // trace instability counter
      trace_cnt_d[c] = trace_cnt_q[c];
      trace_run_d[c] = trace_run_q[c];
      if (frame_i[c].trace_valid) begin
        if (!frame_i[c].trace_same) begin
          trace_run_d[c] = 3'h0;
          if (trace_cnt_q[c] != TRACE_UNSTABLE_LVL) begin
            trace_cnt_d[c] = trace_cnt_q[c] + 4'h1;
          end
        end else if (trace_run_q[c] + 3'h1 >=
                     (thr_q[c][THR_TRACE_SEL] ? TRACE_CLR_LONG
                                              : TRACE_CLR_SHORT)) begin
          trace_cnt_d[c] = 4'h0;
          trace_run_d[c] = 3'h0;
        end else begin
          trace_run_d[c] = trace_run_q[c] + 3'h1;
        end
      end
      // interrupt events, set beats clear
      ev[c] = '0;
      ev[c][IRQ_RDI]    = rdi_d[c] && !rdi_q[c];
      ev[c][IRQ_TRACE]  = (trace_cnt_d[c] == TRACE_UNSTABLE_LVL) &&
                          !trace_unst_q[c];
      ev[c][IRQ_ASYNC]  = (frame_i[c].c2_label == ASYNC_LABEL) &&
                          !async_q[c];
      ev[c][IRQ_PTRIGN] = ignore_d[c];
      irq_d[c] = irq_q[c] | ev[c];
      if (aw_take && wr_hit && wdec.ch == 2'(c) &&
          wdec.idx == IDX_IRQ_STAT && s_axi_wstrb_i[0]) begin
        irq_d[c] = (irq_q[c] & ~s_axi_wdata_i[3:0]) | ev[c];
      end
    end
  end

  // remote defect pattern: bit n of the byte is g1[n-1]
  function automatic logic rdi_match(input logic [7:0] g, input logic e);
    logic [2:0] b;
    b = {g[4], g[5], g[6]};  // bits 5,6,7 in that order
    if (e) begin
      return (b == 3'b010) || (b == 3'b101) || (b == 3'b110);
    end
    return g[4];
  endfunction

  // ****************************************************************
  // per-channel state registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        gap_q[c]        <= HOLDOFF_FRAMES;
        rdi_q[c]        <= 1'b0;
        rdi_run_q[c]    <= 4'h0;
        trace_cnt_q[c]  <= 4'h0;
        trace_run_q[c]  <= 3'h0;
        trace_unst_q[c] <= 1'b0;
        async_q[c]      <= 1'b0;
        summary_q[c]    <= 8'h00;
        irq_q[c]        <= 4'h0;
      end
      ptr_accept_o <= '0;
      irq_o        <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        gap_q[c]        <= gap_d[c];
        rdi_q[c]        <= rdi_d[c];
        rdi_run_q[c]    <= rdi_run_d[c];
        trace_cnt_q[c]  <= trace_cnt_d[c];
        trace_run_q[c]  <= trace_run_d[c];
        trace_unst_q[c] <= (trace_cnt_d[c] == TRACE_UNSTABLE_LVL);
        // flag holds the label comparison; valid only for ds3 payloads
        async_q[c]      <= (frame_i[c].c2_label == ASYNC_LABEL);
        summary_q[c]    <= {frame_i[c].defects[6:3], rdi_d[c],
                            frame_i[c].defects[2:0]};
        irq_q[c]        <= irq_d[c];
        ptr_accept_o[c] <= accept_d[c];
      end
      irq_o <= ((irq_d[0] & mask_q[0]) != 4'h0) ||
               ((irq_d[1] & mask_q[1]) != 4'h0) ||
               ((irq_d[2] & mask_q[2]) != 4'h0);
    end
  end

  // ****************************************************************
  // error tallies
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rei_cnt_q[c] <= 32'h0000_0000;
        b3_cnt_q[c]  <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (frame_i[c].valid) begin
          if (cfg_q[c][CFG_REI_MODE]) begin
            rei_cnt_q[c] <= rei_cnt_q[c] +
                            32'(frame_i[c].g1[3:0] != 4'h0);
          end else begin
            rei_cnt_q[c] <= rei_cnt_q[c] +
                            32'(frame_i[c].g1[3:0]);
          end
          if (cfg_q[c][CFG_B3_MODE]) begin
            b3_cnt_q[c] <= b3_cnt_q[c] +
                           32'(frame_i[c].b3_err != 8'h00);
          end else begin
            b3_cnt_q[c] <= b3_cnt_q[c] +
                           32'(popcount(frame_i[c].b3_err));
          end
        end
      end
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign wdec    = decode(s_axi_awaddr_i);
  assign rdec    = decode(s_axi_araddr_i);
  assign aw_take = s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i;
  assign ar_take = s_axi_arready_o && s_axi_arvalid_i;

  // writable registers exist only at four indices of a page
  always_comb begin
    wr_hit = 1'b0;
    if (!wdec.hit) begin
      wr_hit = 1'b0;
    end else if (wdec.idx == IDX_CONFIG || wdec.idx == IDX_THRESH) begin
      wr_hit = 1'b1;
    end else if (wdec.idx == IDX_IRQ_STAT || wdec.idx == IDX_IRQ_MASK) begin
      wr_hit = 1'b1;
    end
  end

  // write handshake: address and data taken together
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o  <= 1'b0;
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o) begin
        if (s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end else if (s_axi_awvalid_i && s_axi_wvalid_i) begin
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // software-written registers, one copy per page
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c]  <= CONFIG_RESET;
        thr_q[c]  <= THRESH_RESET;
        mask_q[c] <= MASK_RESET;
      end
    end else if (aw_take && wr_hit && s_axi_wstrb_i[0]) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wdec.ch == 2'(c)) begin
          if (wdec.idx == IDX_CONFIG) begin
            cfg_q[c] <= s_axi_wdata_i[3:0];
          end else if (wdec.idx == IDX_THRESH) begin
            thr_q[c] <= s_axi_wdata_i[4:0];
          end else if (wdec.idx == IDX_IRQ_MASK) begin
            mask_q[c] <= s_axi_wdata_i[3:0];
          end
        end
      end
    end
  end

  // read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = rdec.hit;
    if (!rdec.hit) begin
      rd_hit = 1'b0;
    end else if (rdec.idx == IDX_CONFIG) begin
      rd_word = 32'(cfg_q[rdec.ch]);
    end else if (rdec.idx == IDX_PAYLOAD) begin
      rd_word[PAY_ASYNC] = async_q[rdec.ch];
      rd_word[PAY_TRACE] = trace_unst_q[rdec.ch];
    end else if (rdec.idx == IDX_SUMMARY) begin
      rd_word = 32'(summary_q[rdec.ch]);
    end else if (rdec.idx == IDX_THRESH) begin
      rd_word = 32'(thr_q[rdec.ch]);
    end else if (rdec.idx == IDX_REI_CNT) begin
      rd_word = rei_cnt_q[rdec.ch];
    end else if (rdec.idx == IDX_B3_CNT) begin
      rd_word = b3_cnt_q[rdec.ch];
    end else if (rdec.idx == IDX_IRQ_STAT) begin
      rd_word = 32'(irq_q[rdec.ch]);
    end else if (rdec.idx == IDX_IRQ_MASK) begin
      rd_word = 32'(mask_q[rdec.ch]);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read handshake
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
        if (s_axi_rready_i) begin
          s_axi_rvalid_o <= 1'b0;
        end
      end else if (s_axi_arvalid_i) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    hold_off_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].ptr_adj && cfg_q[c][CFG_HOLDOFF] && gap_q[c] < 2'h3
      |=> !ptr_accept_o[c])
      else $error("adjustment inside hold-off was accepted");
    no_hold_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].ptr_adj && !cfg_q[c][CFG_HOLDOFF] |=> ptr_accept_o[c])
      else $error("adjustment dropped with hold-off off");
    rei_bit_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].valid && !cfg_q[c][CFG_REI_MODE] |=>
      rei_cnt_q[c] == $past(rei_cnt_q[c]) + 32'($past(frame_i[c].g1[3:0])))
      else $error("remote error per-bit tally wrong");
    rei_frame_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].valid && cfg_q[c][CFG_REI_MODE] &&
      frame_i[c].g1[3:0] != 4'h0 |=>
      rei_cnt_q[c] == $past(rei_cnt_q[c]) + 32'h0000_0001)
      else $error("remote error per-frame tally wrong");
    b3_bit_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].valid && !cfg_q[c][CFG_B3_MODE] |=>
      b3_cnt_q[c] == $past(b3_cnt_q[c]) +
      32'($countones($past(frame_i[c].b3_err))))
      else $error("parity per-bit tally wrong");
    b3_frame_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].valid && cfg_q[c][CFG_B3_MODE] |=>
      b3_cnt_q[c] - $past(b3_cnt_q[c]) ==
      32'($past(frame_i[c].b3_err) != 8'h00))
      else $error("parity per-frame tally wrong");
    async_flag_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      1'b1 |=> async_q[c] == ($past(frame_i[c].c2_label) == 8'hFC))
      else $error("async payload flag not held");
    trace_unst_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      frame_i[c].trace_valid && !frame_i[c].trace_same &&
      trace_cnt_q[c] == 4'h7 |=> trace_unst_q[c])
      else $error("trace unstable flag not declared");
    rdi_single_a : assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      $rose(rdi_q[c]) && !cfg_q[c][CFG_RDI_TYPE] |->
      $past(frame_i[c].g1[4]))
      else $error("remote defect declared without bit 5");
  end

endmodule // vc3_path_overhead_monitor

// [logic/vc3_poh_pkg.sv]
// ****************************************************************
// constants and types for the vc-3 path overhead monitor
// ****************************************************************
package vc3_poh_pkg;

  // channel pages, selected by address bits 11:8 of the word index
  localparam int          NUM_CH     = 3;
  localparam logic [3:0]  PAGE_FIRST = 4'h2;
  localparam logic [3:0]  PAGE_LAST  = 4'h4;

  // register indices inside a page; byte address is four times index
  localparam logic [7:0]  IDX_CONFIG   = 8'h83;
  localparam logic [7:0]  IDX_PAYLOAD  = 8'h86;
  localparam logic [7:0]  IDX_SUMMARY  = 8'h87;
  localparam logic [7:0]  IDX_THRESH   = 8'h93;
  localparam logic [7:0]  IDX_REI_CNT  = 8'h9C;
  localparam logic [7:0]  IDX_B3_CNT   = 8'hF4;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'hF8;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'hFC;

  // path_monitor_config bit positions
  localparam int CFG_HOLDOFF  = 3;
  localparam int CFG_RDI_TYPE = 2;
  localparam int CFG_REI_MODE = 1;
  localparam int CFG_B3_MODE  = 0;
  // threshold register: bits 3:0 threshold, bit 4 trace clear mode
  localparam int THR_TRACE_SEL = 4;

  // payload_trace_defect_status bit positions
  localparam int PAY_ASYNC = 1;
  localparam int PAY_TRACE = 0;

  // interrupt status bit positions
  localparam int IRQ_RDI    = 0;
  localparam int IRQ_TRACE  = 1;
  localparam int IRQ_ASYNC  = 2;
  localparam int IRQ_PTRIGN = 3;

  // reset values
  localparam logic [3:0]  CONFIG_RESET = 4'h0;
  localparam logic [4:0]  THRESH_RESET = 5'h05;
  localparam logic [3:0]  MASK_RESET   = 4'h0;

  // counts
  localparam logic [1:0]  HOLDOFF_FRAMES     = 2'h3;
  localparam logic [3:0]  TRACE_UNSTABLE_LVL = 4'h8;
  localparam logic [2:0]  TRACE_CLR_SHORT    = 3'h3;
  localparam logic [2:0]  TRACE_CLR_LONG     = 3'h5;
  localparam logic [7:0]  ASYNC_LABEL        = 8'hFC;

  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // one frame's overhead as seen by the monitor, per channel
  typedef struct packed {
    logic       valid;       // one-cycle frame strobe
    logic [7:0] g1;          // received status byte
    logic [7:0] b3_err;      // errored parity bit mask
    logic       ptr_adj;     // pointer adjustment detected
    logic [7:0] c2_label;    // accepted signal label
    logic       trace_valid; // trace message complete
    logic       trace_same;  // equals previous message
    logic [6:0] defects;     // tim,c2u,uneq,plm,rdiu,lop,ais
  } frame_type;

  // decoded register address
  typedef struct packed {
    logic       hit;
    logic [1:0] ch;
    logic [7:0] idx;
  } decode_type;

endpackage

// [verif/far_end_model.sv]
`timescale 1ns/100ps
// ****************
// far-end path terminating equipment, one channel
// ****************
module far_end_model
  import vc3_poh_pkg::*;
(
  // clock
  input  wire logic clk_sys_i,
  // overhead towards the monitor
  output frame_type frame_o
);

  // idle: no strobes, no label, no defects
  initial frame_o = '0;

  // one frame; per-frame bytes are not held once the frame has passed
  task automatic send(input logic [7:0] g, b, input logic pa, tv, ts);
    @(posedge clk_sys_i);
    frame_o.valid       <= 1'b1;
    frame_o.g1          <= g;
    frame_o.b3_err      <= b;
    frame_o.ptr_adj     <= pa;
    frame_o.trace_valid <= tv;
    frame_o.trace_same  <= ts;
    @(posedge clk_sys_i);
    frame_o.valid       <= 1'b0;
    frame_o.ptr_adj     <= 1'b0;
    frame_o.trace_valid <= 1'b0;
    frame_o.g1          <= ~g;
    frame_o.b3_err      <= ~b;
    frame_o.trace_same  <= ~ts;
  endtask

  // accepted label and defect levels
  task automatic lvl(input logic [7:0] c2, input logic [6:0] d);
    @(posedge clk_sys_i);
    frame_o.c2_label <= c2;
    frame_o.defects  <= d;
  endtask

endmodule // far_end_model

// [verif/vc3_path_overhead_monitor_bench.sv]
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module vc3_path_overhead_monitor_bench
  import vc3_poh_pkg::*;
;
  logic              clk_sys_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic [31:0]       awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic [NUM_CH-1:0] acc;
  frame_type         fr_w [NUM_CH];
  logic [1:0]        wq [$];
  logic [33:0]       rq [$];
  int                err_count = 0, check_count = 0, cyc = 0, acc_n = 0;
  logic [31:0]       rnd = 32'h3836_a077, rei_m = '0, b3_m = '0;
  logic [3:0]        cfg = '0;

  // ****************
  // design, far ends, clock
  // ****************
  vc3_path_overhead_monitor dut_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .frame_i(fr_w),
    .ptr_accept_o(acc), .irq_o(irq));

  for (genvar i = 0; i < NUM_CH; i++) begin : pe
    far_end_model pe_u (.clk_sys_i(clk_sys_i), .frame_o(fr_w[i]));
  end

  // free-running clock
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction

  function automatic logic [31:0] ad(input logic [3:0] ch,
                                     input logic [7:0] ix);
    return {18'h0, PAGE_FIRST + ch, ix, 2'b00};
  endfunction

  // bus write: note expected response, hold each channel until taken
  task automatic wr(input logic [3:0] ch, input logic [7:0] ix,
                    input logic [31:0] d, input logic [1:0] r);
    wq.push_back(r);
    @(posedge clk_sys_i);
    awaddr <= ad(ch, ix);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  // bus read: note expected response and data
  task automatic rd(input logic [3:0] ch, input logic [7:0] ix,
                    input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk_sys_i);
    araddr <= ad(ch, ix);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  // channel 0 config with shadow copy
  task automatic cw(input logic [3:0] v);
    cfg = v;
    wr(0, IDX_CONFIG, {28'h0, v}, RESP_OKAY);
  endtask

  // channel 0 frame, tallies kept in step
  task automatic fr(input logic [7:0] g, b, input logic pa, tv, ts);
    rei_m += cfg[CFG_REI_MODE] ? 32'(g[3:0] != 0) : 32'(g[3:0]);
    b3_m += cfg[CFG_B3_MODE] ? 32'(b != 0) : 32'($countones(b));
    pe[0].pe_u.send(g, b, pa, tv, ts);
  endtask

  task automatic ck_irq(input logic v);
    repeat (3) @(posedge clk_sys_i);
    `CHK(irq, v)
  endtask

  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // response monitor, accept pulse count, timeout
  always @(posedge clk_sys_i) begin : mon
    logic [33:0] e;
    cyc++;
    acc_n += $countones(acc[0]);
    if (bvalid && bready) begin
      e = {32'h0, wq.pop_front()};
      `CHK({32'h0, bresp}, e)
    end
    if (rvalid && rready) begin
      e = rq.pop_front();
      `CHK({rresp, rdata}, e)
    end
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    logic [7:0] g;
    logic e;
    int a0;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(0, IDX_CONFIG, {RESP_OKAY, 28'h0, CONFIG_RESET});
    rd(0, IDX_SUMMARY, 34'h0);
    rd(0, IDX_PAYLOAD, 34'h0);
    rd(0, IDX_THRESH, {RESP_OKAY, 27'h0, THRESH_RESET});
    rd(0, IDX_IRQ_MASK, {RESP_OKAY, 28'h0, MASK_RESET});
    rd(0, 8'h00, {RESP_SLVERR, 32'h0});
    wr(0, IDX_SUMMARY, 32'hFF, RESP_SLVERR);
    rd(0, IDX_SUMMARY, 34'h0);
    // all four tally mode pairs with random overhead
    for (int m = 0; m < 4; m++) begin
      cw(m[3:0]);
      for (int j = 0; j < 12; j++) begin
        rnd = nx(rnd);
        fr(j == 0 ? 8'h0 : rnd[7:0], j == 1 ? 8'h0 : rnd[15:8], 0, 0, 0);
      end
      rd(0, IDX_REI_CNT, {RESP_OKAY, rei_m});
      rd(0, IDX_B3_CNT, {RESP_OKAY, b3_m});
    end
    // adjustments one frame apart, then after four frames
    for (int h = 0; h < 2; h++) begin
      cw(h ? 4'h8 : 4'h0);
      repeat (4) fr(8'h0, 8'h0, 0, 0, 0);
      a0 = acc_n;
      fr(8'h0, 8'h0, 1, 0, 0);
      fr(8'h0, 8'h0, 1, 0, 0);
      repeat (4) fr(8'h0, 8'h0, 0, 0, 0);
      fr(8'h0, 8'h0, 1, 0, 0);
      repeat (3) @(posedge clk_sys_i);
      `CHK(acc_n - a0, h ? 2 : 3)
    end
    // every pattern of status-byte bits 5,6,7 in both remote defect modes
    wr(0, IDX_THRESH, 32'h2, RESP_OKAY);
    for (int t = 0; t < 2; t++) begin
      cw(t ? 4'h4 : 4'h0);
      for (int p = 0; p < 8; p++) begin
        rnd = nx(rnd);
        pe[0].pe_u.lvl(8'h0, rnd[6:0]);
        g = {rnd[12], p[0], p[1], p[2], rnd[11:8]};
        repeat (2) fr(g, 8'h0, 0, 0, 0);
        e = t ? (p == 2 || p == 5 || p == 6) : p[2];
        rd(0, IDX_SUMMARY, {RESP_OKAY, 24'h0, rnd[6:3], e, rnd[2:0]});
      end
    end
    // trace instability in both clear modes
    for (int s = 0; s < 2; s++) begin
      wr(0, IDX_THRESH, s ? 32'h12 : 32'h02, RESP_OKAY);
      repeat (7) fr(8'h0, 8'h0, 0, 1, 0);
      rd(0, IDX_PAYLOAD, 34'h0);
      fr(8'h0, 8'h0, 0, 1, 0);
      rd(0, IDX_PAYLOAD, {RESP_OKAY, 32'h1});
      repeat (s ? 3 : 1) fr(8'h0, 8'h0, 0, 1, 1);
      rd(0, IDX_PAYLOAD, {RESP_OKAY, 32'h1});
      repeat (2) fr(8'h0, 8'h0, 0, 1, 1);
      rd(0, IDX_PAYLOAD, 34'h0);
    end
    // payload label flag and its interrupt
    rd(0, IDX_IRQ_STAT, {RESP_OKAY, 32'hB});
    wr(0, IDX_IRQ_STAT, 32'hF, RESP_OKAY);
    rd(0, IDX_IRQ_STAT, 34'h0);
    wr(0, IDX_IRQ_MASK, 32'h4, RESP_OKAY);
    pe[0].pe_u.lvl(ASYNC_LABEL, 7'h0);
    ck_irq(1'b1);
    rd(0, IDX_IRQ_STAT, {RESP_OKAY, 32'h4});
    rd(0, IDX_PAYLOAD, {RESP_OKAY, 32'h2});
    wr(0, IDX_IRQ_MASK, 32'h0, RESP_OKAY);
    ck_irq(1'b0);
    wr(0, IDX_IRQ_MASK, 32'h4, RESP_OKAY);
    ck_irq(1'b1);
    wr(0, IDX_IRQ_STAT, 32'h4, RESP_OKAY);
    ck_irq(1'b0);
    pe[0].pe_u.lvl(8'hFD, 7'h0);
    rd(0, IDX_PAYLOAD, 34'h0);
    // independent pages
    wr(1, IDX_CONFIG, 32'h5, RESP_OKAY);
    wr(2, IDX_CONFIG, 32'hA, RESP_OKAY);
    pe[1].pe_u.send(8'h03, 8'h0, 0, 0, 0);
    rd(0, IDX_CONFIG, {RESP_OKAY, 28'h0, cfg});
    rd(1, IDX_CONFIG, {RESP_OKAY, 32'h5});
    rd(2, IDX_CONFIG, {RESP_OKAY, 32'hA});
    rd(1, IDX_REI_CNT, {RESP_OKAY, 32'h3});
    rd(2, IDX_REI_CNT, 34'h0);
    wr(5, IDX_CONFIG, 32'h1, RESP_SLVERR);
    results();
  end

endmodule // vc3_path_overhead_monitor_bench
